// ===== logic/pdr_map.vh
`ifndef PDR_MAP_VH
`define PDR_MAP_VH
`define PDR_ADDR_MSTP_HIGH   16'hff86
`define PDR_ADDR_MSTP_LOW    16'hff87
`define PDR_ADDR_CTRL_AHIGH  16'hffa0
`define PDR_ADDR_ALOW        16'hffa1
`define PDR_ADDR_BHIGH_CNTH  16'hffa6
`define PDR_ADDR_BLOW_CNTL   16'hffa7
`define PDR_RST_CTRL         8'h30
`define PDR_RST_LEVEL        16'hffff
`define PDR_RST_CNT          16'h0003
`define PDR_RST_MSTP_HIGH    8'h3f
`define PDR_RST_MSTP_LOW     8'hff
`define PDR_BIT_BANK         0
`define PDR_BIT_FMT          1
`define PDR_BIT_CTRL_OE_A    3
`define PDR_BIT_CTRL_OE_B    2
`define PDR_BIT_MSTP_LOW_PWM 3
`define PDR_CNT_STEP         16'h0004
`endif

// ===== logic/pdr_regs.v
// Notes on behaviour
// R1: Two pins carry channel A and B pulses
// R2: Control at FFA0, resets to 30
// R3: Channel A level at FFA0/FFA1, resets FFFF
// R4: Channel B and counter share FFA6/FFA7
// R5: Serial timer select bit routes shared addresses
// R6: Bank bit picks control/counter versus levels
// R7: Two 16-bit read/write level registers
// R8: Word halves pass through holding latch
// R9: Channel A bit 0 always reads one
// R10: Levels reset to FFFF in low power
// R11: Module stop pair at FF86/FF87
// R12: Bits 15:2 data, 1 format, 0 bank on channel B and fixed at 1 on channel A
`timescale 1ns/1ps
`default_nettype none
`include "pdr_map.vh"

module pdr_regs (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire [15:0] bus_addr,
  input  wire        bus_wr,
  input  wire        bus_rd,
  input  wire [7:0]  bus_wdata,
  input  wire        shared_address_select,
  input  wire        low_power_entry,
  output reg  [7:0]  bus_rdata,
  output reg         pulse_out_first,
  output reg         pulse_out_second
);
  // Register state and next values
  reg  [7:0]  ctrl_r;
  reg  [7:0]  ctrl_nxt;
  reg  [15:0] chan_a_level_r;
  reg  [15:0] chan_a_level_nxt;
  reg  [15:0] chan_b_level_r;
  reg  [15:0] chan_b_level_nxt;
  reg  [15:0] cnt_r;
  reg  [15:0] cnt_nxt;
  reg  [7:0]  mstp_high_r;
  reg  [7:0]  mstp_high_nxt;
  reg  [7:0]  mstp_low_r;
  reg  [7:0]  mstp_low_nxt;
  reg  [7:0]  temp_r;
  reg  [7:0]  temp_nxt;
  reg  [7:0]  rdata_nxt;
  reg         pulse_a_nxt;
  reg         pulse_b_nxt;

  // Address decode and access strobes
  wire        pwm_vis;
  wire        bank;
  wire        stopped;
  wire        hit_a0;
  wire        hit_a1;
  wire        hit_a6;
  wire        hit_a7;
  wire        hit_mh;
  wire        hit_ml;
  wire        wr_mh;
  wire        wr_ml;
  wire        wr_ctrl;
  wire        wr_a_high;
  wire        wr_a_low;
  wire        wr_b_high;
  wire        wr_b_low;
  wire        wr_cnt_low;
  wire        rd_a_high;
  wire        rd_b_high;
  wire        rd_cnt_high;

  // Only the low 16 address bits reach this block
  function addr_is;
    input [15:0] addr;
    input [15:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // Counter fields sit at bits 15:2 like the levels, so compare 14-bit fields
  function below;
    input [15:0] count;
    input [15:0] level;
    begin
      below = (count[15:2] < level[15:2]);
    end
  endfunction

  // Channel A bit 0 has no storage, so it is rebuilt as 1 on every path
  function [15:0] pack_a;
    input [7:0] high;
    input [7:0] low;
    begin
      pack_a = {high, low[7:1], 1'b1};
    end
  endfunction

  // Channel B keeps all bits, the lowest being the shared bank bit
  function [15:0] pack_b;
    input [7:0] high;
    input [7:0] low;
    begin
      pack_b = {high, low};
    end
  endfunction

  // Counter write carries the bank bit; bit 1 always reads 1
  function [15:0] pack_cnt;
    input [7:0] high;
    input [7:0] low;
    begin
      pack_cnt = {high, low[7:2], 1'b1, low[`PDR_BIT_BANK]};
    end
  endfunction

  // Only the 14-bit field counts; bank bit is mirrored so both views agree
  function [15:0] step_count;
    input [15:0] count;
    input        bank_bit;
    reg   [15:0] sum;
    begin
      sum        = {count[15:2], 2'b00} + `PDR_CNT_STEP;
      step_count = {sum[15:2], 1'b1, bank_bit};
    end
  endfunction

  assign pwm_vis = ~shared_address_select; // R5
  assign bank    = chan_b_level_r[`PDR_BIT_BANK]; // R6
  assign stopped = mstp_low_r[`PDR_BIT_MSTP_LOW_PWM] | low_power_entry;

  // Shared addresses vanish entirely while the other registers own them
  assign hit_a0  = pwm_vis & addr_is(bus_addr, `PDR_ADDR_CTRL_AHIGH); // R5
  assign hit_a1  = pwm_vis & addr_is(bus_addr, `PDR_ADDR_ALOW); // R5
  assign hit_a6  = pwm_vis & addr_is(bus_addr, `PDR_ADDR_BHIGH_CNTH); // R5
  assign hit_a7  = pwm_vis & addr_is(bus_addr, `PDR_ADDR_BLOW_CNTL); // R5
  assign hit_mh  = addr_is(bus_addr, `PDR_ADDR_MSTP_HIGH); // R11
  assign hit_ml  = addr_is(bus_addr, `PDR_ADDR_MSTP_LOW); // R11

  assign wr_mh       = bus_wr & hit_mh;
  assign wr_ml       = bus_wr & hit_ml;
  assign wr_ctrl     = bus_wr & hit_a0 & ~bank; // R6
  assign wr_a_high   = bus_wr & hit_a0 & bank; // R6
  assign wr_a_low    = bus_wr & hit_a1;
  assign wr_b_high   = bus_wr & hit_a6;
  assign wr_b_low    = bus_wr & hit_a7 & bank; // R6
  assign wr_cnt_low  = bus_wr & hit_a7 & ~bank; // R6
  assign rd_a_high   = bus_rd & hit_a0 & bank;
  assign rd_b_high   = bus_rd & hit_a6 & bank;
  assign rd_cnt_high = bus_rd & hit_a6 & ~bank;

  always @* begin
    rdata_nxt = 8'h00;
    if (hit_mh)
      rdata_nxt = mstp_high_r;
    else if (hit_ml)
      rdata_nxt = mstp_low_r;
    else if (hit_a0)
      rdata_nxt = bank ? chan_a_level_r[15:8] : ctrl_r; // R6
    else if (hit_a1)
      rdata_nxt = {temp_r[7:1], 1'b1}; // R9
    else if (hit_a6)
      rdata_nxt = bank ? chan_b_level_r[15:8] : cnt_r[15:8]; // R6
    else if (hit_a7)
      rdata_nxt = temp_r; // R8
  end

  // High byte reads snapshot the low byte, so a later low read is coherent
  always @* begin
    temp_nxt = temp_r;
    if (rd_a_high)
      temp_nxt = chan_a_level_r[7:0]; // R8
    else if (rd_b_high)
      temp_nxt = chan_b_level_r[7:0]; // R8
    else if (rd_cnt_high)
      temp_nxt = cnt_r[7:0]; // R8
    else if (wr_a_high | wr_b_high)
      temp_nxt = bus_wdata; // R8
  end

  always @* begin
    mstp_high_nxt = mstp_high_r;
    mstp_low_nxt  = mstp_low_r;
    if (wr_mh)
      mstp_high_nxt = bus_wdata; // R11
    if (wr_ml)
      mstp_low_nxt = bus_wdata; // R11
  end

  // A stopped module ignores control writes; software must start it first
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl & ~stopped)
      ctrl_nxt = bus_wdata; // R2
  end

  always @* begin
    chan_a_level_nxt = chan_a_level_r;
    if (stopped)
      chan_a_level_nxt = `PDR_RST_LEVEL; // R10
    else if (wr_a_low)
      chan_a_level_nxt = pack_a(temp_r, bus_wdata); // R7 R8 R9 R12
  end

  always @* begin
    chan_b_level_nxt = chan_b_level_r;
    if (stopped)
      chan_b_level_nxt = `PDR_RST_LEVEL; // R10
    else if (wr_b_low)
      chan_b_level_nxt = pack_b(temp_r, bus_wdata); // R7 R8 R12
    else if (wr_cnt_low)
      chan_b_level_nxt[`PDR_BIT_BANK] = bus_wdata[`PDR_BIT_BANK]; // R6
  end

  always @* begin
    cnt_nxt = step_count(cnt_r, bank);
    if (stopped)
      cnt_nxt = `PDR_RST_CNT;
    else if (wr_cnt_low)
      cnt_nxt = pack_cnt(temp_r, bus_wdata); // R6 R8
  end

  // Simple compare stands in for the pulse engine; format bit is stored only
  always @* begin
    pulse_a_nxt = ctrl_r[`PDR_BIT_CTRL_OE_A] & ~stopped & below(cnt_r, chan_a_level_r); // R1
    pulse_b_nxt = ctrl_r[`PDR_BIT_CTRL_OE_B] & ~stopped & below(cnt_r, chan_b_level_r); // R1
  end

  // Read data stands one cycle only, so idle cycles read back as zero
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      bus_rdata <= rdata_nxt;
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      temp_r <= 8'h00;
    end else begin
      temp_r <= temp_nxt; // R8
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      mstp_high_r <= `PDR_RST_MSTP_HIGH; // R11
      mstp_low_r  <= `PDR_RST_MSTP_LOW; // R11
    end else begin
      mstp_high_r <= mstp_high_nxt;
      mstp_low_r  <= mstp_low_nxt;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r <= `PDR_RST_CTRL; // R2
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      chan_a_level_r <= `PDR_RST_LEVEL; // R3
      chan_b_level_r <= `PDR_RST_LEVEL; // R4
    end else begin
      chan_a_level_r <= chan_a_level_nxt;
      chan_b_level_r <= chan_b_level_nxt;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_r <= `PDR_RST_CNT; // R4
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Pins come straight from flops so no decode glitch reaches them
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pulse_out_first  <= 1'b0;
      pulse_out_second <= 1'b0;
    end else begin
      pulse_out_first  <= pulse_a_nxt; // R1
      pulse_out_second <= pulse_b_nxt; // R1
    end
  end
endmodule // pdr_regs
`default_nettype wire

// ===== bench/pdr_props.sv
`timescale 1ns/1ps
`default_nettype none
module pdr_props(input wire ref_clk, sys_rst, shared_address_select, low_power_entry, bus_rd, bus_wr,
  pulse_out_first, pulse_out_second, input wire [15:0] bus_addr, input wire [7:0] bus_rdata);
  // Cleared by the first write, so the reset-value checks never see later traffic
  reg  nw_r = 1'b1;
  wire s = shared_address_select;
  wire v = bus_rd & nw_r & ~s;
  always @(posedge ref_clk) nw_r <= sys_rst | (nw_r & ~bus_wr);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_pin; $past(sys_rst) |-> !pulse_out_first && !pulse_out_second; endproperty
  property p_ahi; v && bus_addr == 16'hffa0 |=> bus_rdata == 8'hff; endproperty
  property p_bhi; v && bus_addr == 16'hffa6 |=> bus_rdata == 8'hff; endproperty
  property p_mh; v && bus_addr == 16'hff86 |=> bus_rdata == 8'h3f; endproperty
  property p_ml; v && bus_addr == 16'hff87 |=> bus_rdata == 8'hff; endproperty
  property p_hid; bus_rd && s && bus_addr[15:4] == 12'hffa |=> bus_rdata == 8'h00; endproperty
  property p_idl; !bus_rd |=> bus_rdata == 8'h00; endproperty
  property p_lp; low_power_entry ##1 bus_rd && !s && bus_addr == 16'hffa0 |=> bus_rdata == 8'hff; endproperty
  a_pin: assert property (p_pin) else $error("pins");
  a_ahi: assert property (p_ahi) else $error("ahi");
  a_bhi: assert property (p_bhi) else $error("bhi");
  a_mh: assert property (p_mh) else $error("mh");
  a_ml: assert property (p_ml) else $error("ml");
  a_hid: assert property (p_hid) else $error("hid");
  a_idl: assert property (p_idl) else $error("idl");
  a_lp: assert property (p_lp) else $error("lp");
  property p_lpin; low_power_entry |=> !pulse_out_first && !pulse_out_second; endproperty
  a_lpin: assert property (p_lpin) else $error("lpin");
  cover property (pulse_out_first);
  cover property (bus_wr && bus_addr == 16'hffa1);
  cover property (bus_rd && bus_addr == 16'hffa7);
  cover property (bus_rd && s);
endmodule // pdr_props
bind pdr_regs pdr_props u_props(.*);
`default_nettype wire

// ===== bench/pdr_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module pdr_cpu(input wire ref_clk, input wire [7:0] bus_rdata, output logic [15:0] bus_addr,
  output logic bus_wr, bus_rd, output logic [7:0] bus_wdata);
  initial {bus_addr, bus_wr, bus_rd, bus_wdata} = 0;
  task automatic word(input logic w, input logic [15:0] a, d, output logic [15:0] q);
    for (int i = 1; i >= 0; i--) begin
      @(negedge ref_clk);
      {bus_addr, bus_wdata, bus_wr, bus_rd} = {a + 16'(1 - i), d[8*i+:8], w, !w};
      @(negedge ref_clk);
      {bus_wr, bus_rd} = 0;
      q[8*i+:8] = bus_rdata;
    end
  endtask
endmodule // pdr_cpu
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 0, sys_rst = 1, sas = 0, lpe = 0, wr, rd;
  logic [15:0] addr, q, e;
  logic [7:0] rdata, wdata;
  logic [15:0] m_a = 16'hffff, m_b = 16'hffff;
  logic [7:0] m_ctrl = 8'h30, m_t = 8'h00;
  logic m_run = 0, m_p = 0, pf, ps;
  int n_mismatch = 0, num_checks = 0;
  initial forever #50 ref_clk = ~ref_clk;
  pdr_cpu u_pdr_cpu(.ref_clk, .bus_rdata(rdata), .bus_addr(addr), .bus_wr(wr), .bus_rd(rd), .bus_wdata(wdata));
  pdr_regs u_pdr_regs(.ref_clk, .sys_rst, .bus_addr(addr), .bus_wr(wr), .bus_rd(rd), .bus_wdata(wdata),
    .shared_address_select(sas), .low_power_entry(lpe), .bus_rdata(rdata), .pulse_out_first(pf), .pulse_out_second(ps));
  task chk(input logic [15:0] v, x);
    num_checks++;
    if (v !== x) begin n_mismatch++; $display("mismatch %0t %h %h", $time, v, x); end
  endtask
  task results;
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wd(input logic w, input logic [15:0] a, d);
    u_pdr_cpu.word(w, a, d, q);
    if (!sas && a == 16'hffa0 && m_b[0]) m_t = w ? d[15:8] : m_a[7:0];
    if (w && !sas && a == 16'hffa0 && !m_b[0] && m_run && !lpe) m_ctrl = d[15:8];
    if (w && !sas && a == 16'hffa0 && m_run && !lpe) m_a = {m_t, d[7:1], 1'b1};
    if (!sas && a == 16'hffa6) m_t = w ? d[15:8] : m_b[7:0];
    if (w && !sas && a == 16'hffa6 && m_run && !lpe) m_b = m_b[0] ? {m_t, d[7:0]} : {m_b[15:1], d[0]};
    if (w && a == 16'hff86) m_run = !d[3];
  endtask
  initial begin
    e = 16'($urandom(32'h46f81153));
    repeat (3) @(negedge ref_clk);
    sys_rst = 0;
    chk({14'h0, pf, ps}, 16'h0);
    wd(0, 16'hff86, 0); chk(q, 16'h3fff);
    wd(0, 16'hffa0, 0); chk(q, m_a);
    wd(0, 16'hffa6, 0); chk(q, m_b);
    wd(1, 16'hff86, 16'h3ff7);
    repeat (8) begin
      e = 16'($urandom);
      wd(1, 16'hffa0, e);
      wd(1, 16'hffa6, e | 16'h1);
      wd(0, 16'hffa0, 0); chk(q, m_a);
      wd(0, 16'hffa6, 0); chk(q, m_b);
    end
    sas = 1;
    wd(0, 16'hffa0, 0); chk(q, 0);
    wd(1, 16'hffa0, 0);
    sas = 0;
    wd(0, 16'hffa0, 0); chk(q, m_a);
    // Clearing the low bit of level B flips the bank
    wd(1, 16'hffa6, 16'h0002);
    wd(0, 16'hffa0, 0); chk(q[15:8], m_ctrl);
    wd(1, 16'hffa0, 16'h3c00);
    wd(0, 16'hffa0, 0); chk(q[15:8], m_ctrl);
    wd(1, 16'hffa6, 16'h0001);
    wd(0, 16'hffa0, 0); chk(q, m_a);
    wd(0, 16'hffa6, 0); chk(q, m_b);
    // Full-scale A pulses in at least one of three cycles; B at zero never does
    wd(1, 16'hffa0, 16'hffff);
    repeat (3) begin
      @(negedge ref_clk);
      m_p = m_p | pf;
      chk({15'h0, ps}, 16'h0);
    end
    chk({15'h0, m_p}, 16'h1);
    @(negedge ref_clk) lpe = 1;
    m_a = 16'hffff;
    m_b = 16'hffff;
    wd(0, 16'hffa0, 0); chk(q, m_a);
    chk({14'h0, pf, ps}, 16'h0);
    results;
  end
endmodule // testbench
`default_nettype wire
